// ### logic/dpm_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_port_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_is_right,
    input wire logic master_mode,
    input wire logic inhibit_writes,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dpm_pkg::dpm_cmd_t cmd,
    input wire logic [dpm_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [dpm_pkg::DATA_W-1:0] cmd_wdata,
    output logic resp_valid,
    output logic [dpm_pkg::DATA_W-1:0] resp_rdata,
    output logic [dpm_pkg::SEM_N-1:0] sem_held,
    output logic mail_waiting,
    output logic [dpm_pkg::ADDR_W-1:0] mem_addr,
    output logic [dpm_pkg::DATA_W-1:0] mem_data_out,
    input wire logic [dpm_pkg::DATA_W-1:0] mem_data_in,
    output logic mem_data_oe_n,
    output logic mem_ce_n,
    output logic mem_rw_n,
    output logic mem_oe_n,
    output logic semaphore_select_n,
    input wire logic own_mailbox_flag_n,
    input wire logic [dpm_pkg::STACK_DEVS-1:0] conflict_in_n,
    output logic conflict_out_n,
    output logic conflict_oe_n
);
    import dpm_pkg::*;

    typedef struct packed {
        dpm_state_t st;
        logic [CNT_W-1:0] cnt;
        dpm_cmd_t cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic wr;
        logic sem;
        logic then_read;
        logic drv;
        logic resp;
        logic mail;
    } dpm_ctl_t;

    dpm_ctl_t ctl_reg;
    dpm_ctl_t ctl_next;
    logic busy_seen;
    logic sel;
    logic [CNT_W-1:0] strobe_len;
    logic trk_upd;
    logic trk_val;

    // Stacked array: one conflict indication from all devices
    // AND of stacks
    assign busy_seen = ~(&conflict_in_n);
    assign strobe_len = ctl_reg.wr ? WP_CYC : ACC_CYC;

    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.resp = 1'b0;
        ctl_next.mail = ~own_mailbox_flag_n;
        case (ctl_reg.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    ctl_next.cmd = cmd;
                    ctl_next.cnt = '0;
                    ctl_next.addr = cmd_addr;
                    ctl_next.wdata = cmd_wdata;
                    ctl_next.wr = 1'b0;
                    ctl_next.sem = 1'b0;
                    ctl_next.then_read = 1'b0;
                    ctl_next.st = ST_SETTLE;
                    case (cmd)
                        CMD_WRITE: begin
                            ctl_next.wr = 1'b1;
                        end
                        CMD_SEND: begin
                            ctl_next.wr = 1'b1;
                            ctl_next.addr = port_is_right ? MBOX_LEFT : MBOX_RIGHT;
                        end
                        CMD_TAKE: begin
                            ctl_next.addr = port_is_right ? MBOX_RIGHT : MBOX_LEFT;
                        end
                        CMD_SEM_REQ: begin
                            ctl_next.sem = 1'b1;
                            ctl_next.wr = 1'b1;
                            ctl_next.wdata = SEM_TAKE;
                            ctl_next.then_read = 1'b1;
                            ctl_next.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, cmd_addr[SEM_IDX_W-1:0]};
                        end
                        CMD_SEM_FREE: begin
                            ctl_next.sem = 1'b1;
                            ctl_next.wr = 1'b1;
                            ctl_next.wdata = SEM_GIVE;
                            ctl_next.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, cmd_addr[SEM_IDX_W-1:0]};
                        end
                        CMD_SEM_TEST: begin
                            ctl_next.sem = 1'b1;
                            ctl_next.addr = {{(ADDR_W-SEM_IDX_W){1'b0}}, cmd_addr[SEM_IDX_W-1:0]};
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_SETTLE: begin
                if (ctl_reg.cnt == ARB_CYC - CNT_ONE) begin
                    if (!(ctl_reg.wr && master_mode && busy_seen)) begin
                        ctl_next.cnt = '0;
                        ctl_next.st = ST_STROBE;
                    end
                end else begin
                    ctl_next.cnt = ctl_reg.cnt + CNT_ONE;
                end
            end
            ST_STROBE: begin
                if (ctl_reg.wr && master_mode && busy_seen) begin
                    ctl_next.cnt = '0;
                    ctl_next.st = ST_SETTLE;
                end else if (ctl_reg.cnt == strobe_len - CNT_ONE) begin
                    ctl_next.cnt = '0;
                    ctl_next.st = ST_RECOVER;
                    if (!ctl_reg.wr) begin
                        ctl_next.rdata = mem_data_in;
                    end
                end else begin
                    ctl_next.cnt = ctl_reg.cnt + CNT_ONE;
                end
            end
            ST_RECOVER: begin
                if (ctl_reg.then_read) begin
                    ctl_next.then_read = 1'b0;
                    ctl_next.wr = 1'b0;
                    ctl_next.st = ST_SETTLE;
                end else begin
                    ctl_next.resp = 1'b1;
                    ctl_next.st = ST_IDLE;
                end
            end
            default: begin
                ctl_next.st = ST_IDLE;
            end
        endcase
        ctl_next.drv = ctl_next.wr &&
            (ctl_next.st == ST_SETTLE || ctl_next.st == ST_STROBE);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_reg <= '{st: ST_IDLE, cmd: CMD_READ, default: '0};
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign sel = (ctl_reg.st == ST_SETTLE) || (ctl_reg.st == ST_STROBE);
    // semaphore space with chip select high
    assign mem_ce_n = ~(sel && !ctl_reg.sem);
    assign semaphore_select_n = ~(sel && ctl_reg.sem);
    // strobe only inside the select window
    assign mem_rw_n = ~(ctl_reg.st == ST_STROBE && ctl_reg.wr);
    assign mem_oe_n = ~(sel && !ctl_reg.wr);
    assign mem_addr = ctl_reg.addr;
    assign mem_data_out = ctl_reg.wdata;
    assign mem_data_oe_n = ~ctl_reg.drv;
    assign cmd_ready = (ctl_reg.st == ST_IDLE);
    assign resp_valid = ctl_reg.resp;
    assign resp_rdata = ctl_reg.rdata;
    assign mail_waiting = ctl_reg.mail;
    assign conflict_out_n = ~inhibit_writes;
    assign conflict_oe_n = master_mode;

    // Semaphore read bit 0 low means this port holds it
    // bit 0 decides ownership
    assign trk_upd = (ctl_reg.st == ST_RECOVER) && ctl_reg.sem && !ctl_reg.then_read;
    assign trk_val = !ctl_reg.wr && !ctl_reg.rdata[0];

    dpm_sem_track u_track (
        .clock(clock),
        .rst(rst),
        .upd_en(trk_upd),
        .upd_idx(ctl_reg.addr[SEM_IDX_W-1:0]),
        .upd_val(trk_val),
        .held(sem_held)
    );

    a_strobe_in_select: assert property (@(posedge clock) disable iff (rst)
        !mem_rw_n |-> (!mem_ce_n || !semaphore_select_n) && $past(mem_rw_n, 2))
        else $error("write strobe outside select or without setup");
    a_sem_no_ce: assert property (@(posedge clock) disable iff (rst)
        !semaphore_select_n |-> mem_ce_n)
        else $error("chip select active during semaphore access");
    a_busy_abort: assert property (@(posedge clock) disable iff (rst)
        (!mem_rw_n && master_mode && busy_seen) |=> mem_rw_n && ctl_reg.st == ST_SETTLE)
        else $error("write kept going while flagged busy");
    a_slave_drive: assert property (@(posedge clock) disable iff (rst)
        !master_mode |-> !conflict_oe_n && (conflict_out_n == !inhibit_writes))
        else $error("slave inhibit pin not driven correctly");
    a_master_release: assert property (@(posedge clock) disable iff (rst)
        master_mode |-> conflict_oe_n)
        else $error("host drives a device conflict output");
    a_mail_send_addr: assert property (@(posedge clock) disable iff (rst)
        (!mem_rw_n && ctl_reg.cmd == CMD_SEND) |->
            mem_addr == (port_is_right ? MBOX_LEFT : MBOX_RIGHT))
        else $error("mailbox send to wrong address");
    a_take_read: assert property (@(posedge clock) disable iff (rst)
        (ctl_reg.cmd == CMD_TAKE && sel) |->
            !mem_oe_n && mem_rw_n && mem_addr == (port_is_right ? MBOX_RIGHT : MBOX_LEFT))
        else $error("mailbox take is not a read of own box");
    a_sem_relatch: assert property (@(posedge clock) disable iff (rst)
        (ctl_reg.st == ST_RECOVER && ctl_reg.then_read) |->
            (semaphore_select_n && mem_oe_n) ##1 (!semaphore_select_n && !mem_oe_n))
        else $error("semaphore readback without deselect gap");
    a_sem_claim_data: assert property (@(posedge clock) disable iff (rst)
        (!semaphore_select_n && !mem_rw_n && ctl_reg.cmd == CMD_SEM_REQ) |->
            !mem_data_oe_n && mem_data_out == SEM_TAKE)
        else $error("semaphore claim does not write zero");
    a_resp_pulse: assert property (@(posedge clock) disable iff (rst)
        resp_valid |-> cmd_ready ##1 !resp_valid)
        else $error("response not a single pulse");
endmodule : dpm_port_ctrl
`default_nettype wire

// ### logic/dpm_pkg.sv
package dpm_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int SEM_N = 8;
    localparam int SEM_IDX_W = 3;
    localparam int STACK_DEVS = 2;
    localparam int CNT_W = 3;
    localparam logic [ADDR_W-1:0] MBOX_LEFT = 13'h1ffe;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT = 13'h1fff;
    localparam logic [DATA_W-1:0] SEM_TAKE = 8'h00;
    localparam logic [DATA_W-1:0] SEM_GIVE = 8'h01;
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_ARB_NS = 45;
    localparam int T_WP_NS = 50;
    localparam int T_ACC_NS = 55;
    localparam logic [CNT_W-1:0] ARB_CYC = CNT_W'((T_ARB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_WRITE = 3'h1,
        CMD_SEND = 3'h2,
        CMD_TAKE = 3'h3,
        CMD_SEM_REQ = 3'h4,
        CMD_SEM_FREE = 3'h5,
        CMD_SEM_TEST = 3'h6
    } dpm_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETTLE = 4'h2,
        ST_STROBE = 4'h4,
        ST_RECOVER = 4'h8
    } dpm_state_t;
endpackage : dpm_pkg

// ### logic/dpm_sem_track.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_sem_track (
    input wire logic clock,
    input wire logic rst,
    input wire logic upd_en,
    input wire logic [dpm_pkg::SEM_IDX_W-1:0] upd_idx,
    input wire logic upd_val,
    output logic [dpm_pkg::SEM_N-1:0] held
);
    import dpm_pkg::*;

    typedef struct packed {
        logic [SEM_N-1:0] held;
    } dpm_trk_t;

    dpm_trk_t trk_reg;
    dpm_trk_t trk_next;

    // One ownership bit per semaphore
    genvar g;
    generate
        for (g = 0; g < SEM_N; g++) begin : g_bit
            always_comb begin
                trk_next.held[g] = trk_reg.held[g];
                if (upd_en && upd_idx == SEM_IDX_W'(g)) begin
                    trk_next.held[g] = upd_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trk_reg <= '0;
        end else begin
            trk_reg <= trk_next;
        end
    end

    assign held = trk_reg.held;
endmodule : dpm_sem_track
`default_nettype wire

// ### testbench/dpm_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpm_dev_model (
    input wire logic clock,
    input wire logic master,
    input wire logic [1:0] ce_n,
    input wire logic [1:0] rw_n,
    input wire logic [1:0] oe_n,
    input wire logic [1:0] sem_n,
    input wire logic [1:0] cw,
    input wire logic [1:0][12:0] addr,
    input wire logic [1:0][7:0] din,
    input wire logic [1:0] doe_n,
    output logic [1:0][7:0] dout,
    output logic [1:0] flag_n = 2'h3,
    output logic [1:0] busy_n = 2'h3
);
    logic [7:0] mem [0:8191];
    logic [1:0][7:0] tok = '0, pend = '0, wd, last = '0;
    logic [1:0][12:0] wa;
    logic [1:0] wp = 2'h0, ws, selq = 2'h0, ok;
    logic [1:0][7:0] semq = '0;
    logic [1:0] sact = 2'h0;
    assign ok = master ? busy_n : cw;

    task automatic semw(input int p, input logic [2:0] i, input logic b);
        if (b && tok[p][i]) begin
            tok[p][i] = 1'h0;
            tok[1 - p][i] = pend[1 - p][i];
            pend[1 - p][i] = 1'h0;
        end else if (b) pend[p][i] = 1'h0;
        else if (tok[1 - p][i]) pend[p][i] = 1'h1;
        else tok[p][i] = 1'h1;
    endtask : semw

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            dout[p] = ~last[p];
            if (!oe_n[p] && rw_n[p] && !sem_n[p]) begin
                dout[p] = sact[p] ? semq[p] : {8{!tok[p][addr[p][2:0]]}};
            end else if (!oe_n[p] && rw_n[p] && !ce_n[p]) dout[p] = mem[addr[p]];
        end
    end

    always @(posedge clock) begin
        if (ce_n != 2'h0 || addr[0] != addr[1]) busy_n <= 2'h3;
        else if (busy_n == 2'h3) busy_n <= (selq == 2'h2) ? 2'h2 : 2'h1;
        selq <= ~ce_n;
        last <= dout;
        for (int p = 0; p < 2; p++) begin
            sact[p] <= !sem_n[p] && !oe_n[p];
            if (!sem_n[p] && !oe_n[p] && !sact[p]) semq[p] <= {8{!tok[p][addr[p][2:0]]}};
            if (!ce_n[p] && !oe_n[p] && addr[p] == (p ? 13'h1fff : 13'h1ffe)) flag_n[p] <= 1'h1;
            if (!rw_n[p] && !(ce_n[p] && sem_n[p])) begin
                wp[p] = 1'h1;
                ws[p] = !sem_n[p];
                wa[p] = addr[p];
                // Undriven data bus reads back inverted
                wd[p] = doe_n[p] ? ~din[p] : din[p];
            end else if (wp[p]) begin
                wp[p] = 1'h0;
                if (ok[p] && ws[p]) semw(p, wa[p][2:0], wd[p][0]);
                else if (ok[p]) begin
                    mem[wa[p]] <= wd[p];
                    if (wa[p] == (p ? 13'h1ffe : 13'h1fff)) flag_n[1 - p] <= 1'h0;
                end
            end
        end
    end
endmodule : dpm_dev_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpm_pkg::*;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic master = 1'h1;
    logic [1:0] cv = 2'h0, inh = 2'h0, stk_n = 2'h3;
    logic [1:0] rdy, rv, ce_n, rw_n, oe_n, sem_n, co_n, co_oe_n, busy_n, flag_n, mw, cw;
    logic [1:0] doe_n;
    logic [1:0][12:0] ca = '0, ma;
    logic [1:0][7:0] cd = '0, mo, mi, rd, held;
    dpm_cmd_t cm [2] = '{CMD_READ, CMD_READ};
    logic [7:0] got [2];
    int failures = 0, checks = 0, cyc = 0, resps [2] = '{0, 0};

    always #12.5 clock = ~clock;

    for (genvar g = 0; g < 2; g++) begin : port
        assign cw[g] = master ? busy_n[g] : (co_oe_n[g] | co_n[g]);
        dpm_port_ctrl dut_u (.clock(clock), .rst(rst), .port_is_right(g == 1),
            .master_mode(master), .inhibit_writes(inh[g]), .cmd_valid(cv[g]),
            .cmd_ready(rdy[g]), .cmd(cm[g]), .cmd_addr(ca[g]), .cmd_wdata(cd[g]),
            .resp_valid(rv[g]), .resp_rdata(rd[g]), .sem_held(held[g]), .mail_waiting(mw[g]),
            .mem_addr(ma[g]), .mem_data_out(mo[g]), .mem_data_in(mi[g]),
            .mem_data_oe_n(doe_n[g]),
            .mem_ce_n(ce_n[g]), .mem_rw_n(rw_n[g]), .mem_oe_n(oe_n[g]),
            .semaphore_select_n(sem_n[g]), .own_mailbox_flag_n(flag_n[g]),
            .conflict_in_n({stk_n[g], cw[g]}), .conflict_out_n(co_n[g]),
            .conflict_oe_n(co_oe_n[g]));
    end
    dpm_dev_model m_u (.clock(clock), .master(master), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n),
        .sem_n(sem_n), .cw(cw), .addr(ma), .din(mo), .doe_n(doe_n), .dout(mi),
        .flag_n(flag_n),
        .busy_n(busy_n));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic run(input int p, input dpm_cmd_t c, input logic [12:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clock);
        cv[p] <= 1'h1;
        cm[p] <= c;
        ca[p] <= a;
        cd[p] <= d;
        do @(negedge clock); while (rdy[p] !== 1'h1);
        @(posedge clock);
        cv[p] <= 1'h0;
        while (rv[p] !== 1'h1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (n >= 400) failures++;
        got[p] = rd[p];
        resps[p]++;
    endtask : run

    task automatic t_mail;
        run(0, CMD_WRITE, 13'h0123, 8'ha5);
        run(1, CMD_READ, 13'h0123, 8'h0);
        chk(got[1], 8'ha5);
        run(0, CMD_SEND, 13'h0, 8'h3c);
        repeat (3) @(negedge clock);
        chk({6'h0, mw}, 8'h2);
        run(1, CMD_TAKE, 13'h0, 8'h0);
        repeat (3) @(negedge clock);
        chk({got[1][5:0], mw}, 8'hf0);
        run(1, CMD_SEND, 13'h0, 8'hc3);
        repeat (3) @(negedge clock);
        chk({6'h0, mw}, 8'h1);
        run(0, CMD_TAKE, 13'h0, 8'h0);
        repeat (3) @(negedge clock);
        chk({got[0][5:0], mw}, 8'h0c);
        $display("test mail done");
    endtask : t_mail

    task automatic t_sem;
        run(0, CMD_SEM_REQ, 13'h1ffd, 8'h0);
        chk(got[0] | held[0], 8'h20);
        run(1, CMD_SEM_REQ, 13'h0005, 8'h0);
        chk(got[1] & ~held[1], 8'hff);
        run(0, CMD_SEM_FREE, 13'h0005, 8'h0);
        run(1, CMD_SEM_TEST, 13'h0005, 8'h0);
        chk(got[1] | held[1], 8'h20);
        run(0, CMD_SEM_TEST, 13'h0005, 8'h0);
        chk(got[0], 8'hff);
        run(0, CMD_SEM_TEST, 13'h0002, 8'h0);
        chk(got[0], 8'hff);
        run(1, CMD_SEM_FREE, 13'h0005, 8'h0);
        run(0, CMD_SEM_TEST, 13'h0005, 8'h0);
        run(1, CMD_SEM_TEST, 13'h0005, 8'h0);
        chk(got[0] & got[1], 8'hff);
        fork
            run(0, CMD_SEM_REQ, 13'h0003, 8'h0);
            run(1, CMD_SEM_REQ, 13'h0003, 8'h0);
        join
        chk(got[0] ^ got[1], 8'hff);
        $display("test semaphore done");
    endtask : t_sem

    task automatic t_slave;
        @(posedge clock);
        master <= 1'h0;
        run(0, CMD_WRITE, 13'h0050, 8'h22);
        @(posedge clock);
        inh[0] <= 1'h1;
        run(0, CMD_WRITE, 13'h0050, 8'h99);
        chk({6'h0, co_oe_n[0], co_n[0]}, 8'h0);
        run(1, CMD_READ, 13'h0050, 8'h0);
        chk(got[1], 8'h22);
        @(posedge clock);
        inh[0] <= 1'h0;
        run(0, CMD_WRITE, 13'h0050, 8'h44);
        run(1, CMD_READ, 13'h0050, 8'h0);
        chk(got[1], 8'h44);
        @(posedge clock);
        master <= 1'h1;
        $display("test slave done");
    endtask : t_slave

    task automatic t_busy;
        int n;
        fork
            run(0, CMD_WRITE, 13'h0200, 8'h5a);
            begin
                @(posedge clock);
                run(1, CMD_WRITE, 13'h0200, 8'h77);
            end
        join
        run(0, CMD_READ, 13'h0200, 8'h0);
        chk(got[0], 8'h77);
        n = resps[1];
        fork
            run(1, CMD_WRITE, 13'h0300, 8'h66);
        join_none
        // Stacked device flags busy in mid-strobe
        do @(negedge clock); while (rw_n[1] !== 1'h0);
        @(posedge clock);
        stk_n[1] <= 1'h0;
        repeat (40) @(negedge clock);
        chk(8'(resps[1] - n), 8'h0);
        @(posedge clock);
        stk_n[1] <= 1'h1;
        wait fork;
        chk(8'(resps[1] - n), 8'h1);
        run(0, CMD_READ, 13'h0300, 8'h0);
        chk(got[0], 8'h66);
        $display("test busy done");
    endtask : t_busy

    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        t_mail();
        t_sem();
        t_slave();
        t_busy();
        conclude();
    end
endmodule : tb
`default_nettype wire
